// ===== design/ditd_top.v
// drive input terminal decoder: six programmable terminals to commands
// synchronises the terminal inputs itself and assumes a one-cycle register port
//
// Design decisions made here: the strobed register port and the register offsets.
`include "ditd_defs.vh"
module ditd_top #(
	parameter [31:0] DEB_CYC = `DITD_DEB_CYC,
	parameter [31:0] RPT_FAST_CYC = `DITD_RPT_FAST_CYC,
	parameter [31:0] RPT_SLOW_CYC = `DITD_RPT_SLOW_CYC
) (
	input wire i_core_clk,
	input wire i_reset,
	input wire i_ce,
	input wire [5:0] i_terminal,
	input wire i_panel_key,
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	output reg o_run,
	output reg o_reverse,
	output reg o_jog,
	output reg o_coast_stop,
	output reg [1:0] o_ramp_sel,
	output reg [3:0] o_seg_speed,
	output reg [1:0] o_hml_sel,
	output reg o_force_main_freq,
	output reg o_force_second_analog,
	output reg o_force_keyboard,
	output reg o_overheat,
	output reg o_ext_fault,
	output reg o_fault_reset,
	output reg o_pid_enable,
	output reg o_draft_enable,
	output reg o_yarn_stop,
	output reg o_timer1_done,
	output reg o_timer2_done,
	output reg o_zero_count_display,
	output reg [15:0] o_freq_offset
);
	reg [7:0] fn_r [0:5];
	reg [7:0] cfg_r;
	reg [15:0] jog_frequency_setting_r;
	reg [15:0] fmax_r;
	reg [15:0] fmin_r;
	reg [31:0] t1_len_r;
	reg [31:0] t2_len_r;
	reg [31:0] t1_cnt_r;
	reg [31:0] t2_cnt_r;
	reg t1_on_r;
	reg t2_on_r;
	reg [15:0] count_r;
	reg [31:0] rpt_cnt_r;
	reg [7:0] rpt_n_r;
	reg key_tog_r;
	reg jog_dir_r;
	wire [5:0] lvl;
	wire [5:0] rise;
	wire [5:0] fall;
	integer k;

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_deb
			ditd_debounce #(
				.CNT_W(32),
				.HOLD(DEB_CYC)
			) u_deb (
				.i_core_clk(i_core_clk),
				.i_reset(i_reset),
				.i_ce(i_ce),
				.i_pin(i_terminal[g]),
				.o_level(lvl[g]),
				.o_rise(rise[g]),
				.o_fall(fall[g])
			);
		end
	endgenerate

	// which terminals carry a function; undefined codes match nothing
	function [5:0] fn_hit;
		input [7:0] code;
		input [47:0] fns;
		integer i;
		begin
			for (i = 0; i < 6; i = i + 1)
				fn_hit[i] = (fns[i*8 +: 8] == code);
		end
	endfunction

	wire [47:0] fns = {fn_r[5], fn_r[4], fn_r[3], fn_r[2], fn_r[1], fn_r[0]};
	wire src_ext = cfg_r[`DITD_CFG_SRC];
	wire [1:0] seg_mode = cfg_r[`DITD_CFG_SEG_LO +: 2];
	wire [1:0] key_fn = cfg_r[`DITD_CFG_KEY_LO +: 2];
	wire key_rise = i_panel_key & ~key_tog_r;
	wire lv_run = |(lvl & fn_hit(`DITD_FN_RUN, fns));
	wire rs_fwd = |(rise & fn_hit(`DITD_FN_FWD, fns));
	wire rs_rev = |(rise & fn_hit(`DITD_FN_REV, fns));
	wire lv_fwd = |(lvl & fn_hit(`DITD_FN_FWD, fns));
	wire lv_rev = |(lvl & fn_hit(`DITD_FN_REV, fns));
	wire has_fwd = |fn_hit(`DITD_FN_FWD, fns);
	wire has_run = |fn_hit(`DITD_FN_RUN, fns);
	wire has_stop = |fn_hit(`DITD_FN_STOP, fns);
	// stop button is normally closed: open contact means stop
	wire stop_open = |(~lvl & fn_hit(`DITD_FN_STOP, fns));
	wire lv_dir = |(lvl & fn_hit(`DITD_FN_DIR, fns));
	wire lv_jog = |(lvl & fn_hit(`DITD_FN_JOG, fns));
	wire lv_jogf = |(lvl & fn_hit(`DITD_FN_JOGF, fns));
	wire lv_jogr = |(lvl & fn_hit(`DITD_FN_JOGR, fns));
	wire any_jog = lv_jog | lv_jogf | lv_jogr;
	wire rs_t1 = |(rise & fn_hit(`DITD_FN_TMR1, fns));
	wire rs_t2 = |(rise & fn_hit(`DITD_FN_TMR2, fns));
	wire lv_up = |(lvl & fn_hit(`DITD_FN_UP, fns));
	wire lv_dn = |(lvl & fn_hit(`DITD_FN_DN, fns));
	wire rs_updn = |(rise & (fn_hit(`DITD_FN_UP, fns) |
		fn_hit(`DITD_FN_DN, fns)));
	wire rs_pulse = |(rise & fn_hit(`DITD_FN_PULSE, fns));
	wire rs_crst = |(rise & fn_hit(`DITD_FN_CRST, fns));
	wire crst = rs_crst | (key_rise & key_fn == 2'd2);
	wire [15:0] jog_clamp = (jog_frequency_setting_r > fmax_r) ? fmax_r :
		(jog_frequency_setting_r < fmin_r) ? fmin_r :
		jog_frequency_setting_r;
	wire running = o_run & ~o_jog;
	// a jog is taken only from standby, with the terminal source selected, fault free, even while the keyboard is forced
	wire jog_go = ~o_run & any_jog & src_ext &
		~(o_ext_fault | o_yarn_stop | o_overheat);

	always @(posedge i_core_clk) begin
		if (i_reset) begin
			fn_r[0] <= `DITD_R_FN1;
			fn_r[1] <= `DITD_R_FN2;
			fn_r[2] <= `DITD_R_FN3;
			fn_r[3] <= `DITD_R_FN4;
			fn_r[4] <= `DITD_R_FN5;
			fn_r[5] <= `DITD_R_FN6;
			cfg_r <= `DITD_R_CFG;
			jog_frequency_setting_r <= `DITD_R_JOG;
			fmax_r <= `DITD_R_FMAX;
			fmin_r <= `DITD_R_FMIN;
			t1_len_r <= `DITD_TMR_DEF;
			t2_len_r <= `DITD_TMR_DEF;
			o_rdata <= 32'h00000000;
		end else if (i_ce) begin
			o_rdata <= 32'h00000000;
			if (i_wr) begin
				case (i_addr)
				`DITD_A_FN1, `DITD_A_FN2, `DITD_A_FN3,
				`DITD_A_FN4, `DITD_A_FN5, `DITD_A_FN6: begin
					fn_r[i_addr[2:0]] <= i_wdata[7:0];
				end
				`DITD_A_CFG: cfg_r <= i_wdata[7:0];
				`DITD_A_JOG: begin
					if (i_wdata[15:0] <= `DITD_JOG_LIM)
						jog_frequency_setting_r <= i_wdata[15:0];
				end
				`DITD_A_FMAX: fmax_r <= i_wdata[15:0];
				`DITD_A_FMIN: fmin_r <= i_wdata[15:0];
				`DITD_A_T1: t1_len_r <= i_wdata;
				`DITD_A_T2: t2_len_r <= i_wdata;
				default: ;
				endcase
			end
			if (i_rd) begin
				case (i_addr)
				`DITD_A_FN1, `DITD_A_FN2, `DITD_A_FN3,
				`DITD_A_FN4, `DITD_A_FN5, `DITD_A_FN6: begin
					o_rdata <= {24'h000000, fn_r[i_addr[2:0]]};
				end
				`DITD_A_CFG: o_rdata <= {24'h000000, cfg_r};
				`DITD_A_JOG: o_rdata <= {16'h0000, jog_frequency_setting_r};
				`DITD_A_FMAX: o_rdata <= {16'h0000, fmax_r};
				`DITD_A_FMIN: o_rdata <= {16'h0000, fmin_r};
				`DITD_A_T1: o_rdata <= t1_len_r;
				`DITD_A_T2: o_rdata <= t2_len_r;
				`DITD_A_ST: o_rdata <= {16'h0000, 2'b00, lvl, o_jog,
					o_reverse, o_run, t2_on_r, t1_on_r,
					o_timer2_done, o_timer1_done, o_zero_count_display};
				`DITD_A_CNT: o_rdata <= {16'h0000, count_r};
				`DITD_A_UPDN: o_rdata <= {16'h0000, o_freq_offset};
				default: o_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// run, direction and jog state
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			o_run <= 1'b0;
			o_reverse <= 1'b0;
			o_jog <= 1'b0;
			o_coast_stop <= 1'b0;
			jog_dir_r <= 1'b0;
			key_tog_r <= 1'b0;
			o_force_keyboard <= 1'b0;
		end else if (i_ce) begin
			key_tog_r <= i_panel_key;
			o_coast_stop <= 1'b0;
			if (key_rise && key_fn == 2'd1)
				o_force_keyboard <= ~o_force_keyboard;
			if (key_fn != 2'd1)
				o_force_keyboard <= 1'b0;
			if (o_jog) begin
				if (!any_jog) begin
					o_jog <= 1'b0;
					o_run <= 1'b0;
					o_coast_stop <= 1'b1;
				end
				// other commands are not looked at while jogging
			end else if (o_ext_fault || o_yarn_stop || o_overheat) begin
				o_run <= 1'b0;
			end else if (jog_go) begin
				o_jog <= 1'b1;
				o_run <= 1'b1;
				o_reverse <= lv_jogr | (lv_jog & o_reverse);
			end else if (src_ext && !o_force_keyboard) begin
				if (has_stop) begin
					if (stop_open) begin
						o_run <= 1'b0;
					end else if (rs_fwd) begin
						o_run <= 1'b1;
						o_reverse <= 1'b0;
					end else if (rs_rev) begin
						o_run <= 1'b1;
						o_reverse <= 1'b1;
					end
				end else if (has_run) begin
					o_run <= lv_run;
					o_reverse <= lv_dir;
				end else if (has_fwd) begin
					o_run <= lv_fwd | lv_rev;
					o_reverse <= lv_rev & ~lv_fwd;
				end
			end
			if (key_rise && key_fn == 2'd0 && !o_jog)
				o_reverse <= ~o_reverse;
		end
	end

	// static selections and protections
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			o_ramp_sel <= 2'd0;
			o_seg_speed <= 4'h0;
			o_hml_sel <= 2'd0;
			o_force_main_freq <= 1'b0;
			o_force_second_analog <= 1'b0;
			o_overheat <= 1'b0;
			o_ext_fault <= 1'b0;
			o_fault_reset <= 1'b0;
			o_pid_enable <= 1'b0;
			o_draft_enable <= 1'b0;
			o_yarn_stop <= 1'b0;
		end else if (i_ce) begin
			// a refused jog must not switch the ramp set
			if (jog_go || o_jog)
				o_ramp_sel <= 2'd3;
			else if (seg_mode == 2'd1)
				o_ramp_sel <= 2'd0;
			else
				o_ramp_sel <= {|(lvl & fn_hit(`DITD_FN_RMP2, fns)),
					|(lvl & fn_hit(`DITD_FN_RMP1, fns))};
			o_seg_speed <= {|(lvl & fn_hit(`DITD_FN_SEG4, fns)),
				|(lvl & fn_hit(`DITD_FN_SEG3, fns)),
				|(lvl & fn_hit(`DITD_FN_SEG2, fns)),
				|(lvl & fn_hit(`DITD_FN_SEG1, fns))};
			if (|(lvl & fn_hit(`DITD_FN_HI, fns)))
				o_hml_sel <= 2'd3;
			else if (|(lvl & fn_hit(`DITD_FN_MID, fns)))
				o_hml_sel <= 2'd2;
			else if (|(lvl & fn_hit(`DITD_FN_LO, fns)))
				o_hml_sel <= 2'd1;
			else
				o_hml_sel <= 2'd0;
			o_force_main_freq <= |(lvl & fn_hit(`DITD_FN_MAINF, fns));
			o_force_second_analog <= |(lvl & fn_hit(`DITD_FN_AI2, fns));
			o_overheat <= |(lvl & fn_hit(`DITD_FN_HEAT, fns));
			o_ext_fault <= |(lvl & fn_hit(`DITD_FN_ECUT, fns));
			o_fault_reset <= |(rise & fn_hit(`DITD_FN_RST, fns));
			o_pid_enable <= running &
				|(lvl & fn_hit(`DITD_FN_PID, fns));
			o_draft_enable <= |(lvl & fn_hit(`DITD_FN_DRAFT, fns));
			o_yarn_stop <= lvl[3] & (fn_r[3] == `DITD_FN_YARN);
		end
	end

	// timers, pulse counter, up/down offset
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			t1_on_r <= 1'b0;
			t2_on_r <= 1'b0;
			t1_cnt_r <= 32'h00000000;
			t2_cnt_r <= 32'h00000000;
			o_timer1_done <= 1'b0;
			o_timer2_done <= 1'b0;
			count_r <= 16'h0000;
			o_zero_count_display <= 1'b1;
			o_freq_offset <= 16'h0000;
			rpt_cnt_r <= 32'h00000000;
			rpt_n_r <= 8'h00;
		end else if (i_ce) begin
			if (rs_t1) begin
				t1_on_r <= 1'b1;
				t1_cnt_r <= 32'h00000000;
				o_timer1_done <= 1'b0;
			end else if (t1_on_r) begin
				if (t1_cnt_r >= t1_len_r) begin
					t1_on_r <= 1'b0;
					o_timer1_done <= 1'b1;
				end else begin
					t1_cnt_r <= t1_cnt_r + 32'h00000001;
				end
			end
			if (rs_t2) begin
				t2_on_r <= 1'b1;
				t2_cnt_r <= 32'h00000000;
				o_timer2_done <= 1'b0;
			end else if (t2_on_r) begin
				if (t2_cnt_r >= t2_len_r) begin
					t2_on_r <= 1'b0;
					o_timer2_done <= 1'b1;
				end else begin
					t2_cnt_r <= t2_cnt_r + 32'h00000001;
				end
			end
			if (crst) begin
				count_r <= 16'h0000;
				o_zero_count_display <= 1'b1;
			end else if (rs_pulse && count_r != `DITD_CNT_MAX) begin
				count_r <= count_r + 16'h0001;
				o_zero_count_display <= 1'b0;
			end
			if (running && (lv_up ^ lv_dn)) begin
				if (rs_updn || rpt_cnt_r == 32'h00000000) begin
					if (lv_up && o_freq_offset != 16'hffff)
						o_freq_offset <= o_freq_offset + 16'h0001;
					if (lv_dn && o_freq_offset != 16'h0000)
						o_freq_offset <= o_freq_offset - 16'h0001;
					if (rs_updn)
						rpt_n_r <= 8'h00;
					else if (rpt_n_r != `DITD_RPT_FAST_N)
						rpt_n_r <= rpt_n_r + 8'h01;
					rpt_cnt_r <= (rpt_n_r < `DITD_RPT_FAST_N) ?
						RPT_FAST_CYC : RPT_SLOW_CYC;
				end else begin
					rpt_cnt_r <= rpt_cnt_r - 32'h00000001;
				end
			end else begin
				rpt_cnt_r <= RPT_FAST_CYC;
				rpt_n_r <= 8'h00;
			end
		end
	end
endmodule // ditd_top

// ===== design/ditd_defs.vh
// constants for the drive input terminal decoder
// assumes a 50 MHz core clock and a plain register port
`ifndef DITD_DEFS_VH
`define DITD_DEFS_VH
`define DITD_CLK_MHZ 50
`define DITD_DEB_MS 2
`define DITD_DEB_CYC (`DITD_DEB_MS * `DITD_CLK_MHZ * 1000)
`define DITD_RPT_FAST_MS 50
`define DITD_RPT_FAST_CYC (`DITD_RPT_FAST_MS * `DITD_CLK_MHZ * 1000)
`define DITD_RPT_SLOW_MS 200
`define DITD_RPT_SLOW_CYC (`DITD_RPT_SLOW_MS * `DITD_CLK_MHZ * 1000)
`define DITD_RPT_FAST_N 8'h0a
`define DITD_TMR_DEF 32'h02faf080
`define DITD_A_FN1 4'h0
`define DITD_A_FN2 4'h1
`define DITD_A_FN3 4'h2
`define DITD_A_FN4 4'h3
`define DITD_A_FN5 4'h4
`define DITD_A_FN6 4'h5
`define DITD_A_CFG 4'h6
`define DITD_A_JOG 4'h7
`define DITD_A_FMAX 4'h8
`define DITD_A_FMIN 4'h9
`define DITD_A_T1 4'ha
`define DITD_A_T2 4'hb
`define DITD_A_ST 4'hc
`define DITD_A_CNT 4'hd
`define DITD_A_UPDN 4'he
`define DITD_R_FN1 8'h02
`define DITD_R_FN2 8'h03
`define DITD_R_FN3 8'h0e
`define DITD_R_FN4 8'h16
`define DITD_R_FN5 8'h17
`define DITD_R_FN6 8'h18
`define DITD_R_JOG 16'h0032
`define DITD_R_FMAX 16'h01f4
`define DITD_R_FMIN 16'h0000
`define DITD_JOG_LIM 16'h2710
`define DITD_CNT_MAX 16'hffff
// cfg fields: [0] cmd source, [2:1] segment mode, [4:3] panel key
`define DITD_CFG_SRC 0
`define DITD_CFG_SEG_LO 1
`define DITD_CFG_KEY_LO 3
`define DITD_R_CFG 8'h00
`define DITD_FN_RUN 8'h01
`define DITD_FN_FWD 8'h02
`define DITD_FN_REV 8'h03
`define DITD_FN_STOP 8'h04
`define DITD_FN_DIR 8'h05
`define DITD_FN_JOG 8'h06
`define DITD_FN_JOGF 8'h07
`define DITD_FN_JOGR 8'h08
`define DITD_FN_TMR1 8'h09
`define DITD_FN_TMR2 8'h0a
`define DITD_FN_MAINF 8'h0b
`define DITD_FN_HEAT 8'h0c
`define DITD_FN_ECUT 8'h0d
`define DITD_FN_RST 8'h0e
`define DITD_FN_AI2 8'h0f
`define DITD_FN_RMP1 8'h11
`define DITD_FN_RMP2 8'h12
`define DITD_FN_SEG1 8'h13
`define DITD_FN_SEG2 8'h14
`define DITD_FN_SEG3 8'h15
`define DITD_FN_HI 8'h16
`define DITD_FN_MID 8'h17
`define DITD_FN_LO 8'h18
`define DITD_FN_PID 8'h19
`define DITD_FN_SEG4 8'h1a
`define DITD_FN_UP 8'h1b
`define DITD_FN_DN 8'h1c
`define DITD_FN_DRAFT 8'h1d
`define DITD_FN_PULSE 8'h1f
`define DITD_FN_CRST 8'h20
`define DITD_FN_YARN 8'h21
`endif

// ===== design/ditd_debounce.v
// synchroniser and debouncer for one input terminal
// assumes the terminal is a slow contact, sampled on the core clock
module ditd_debounce #(
	parameter CNT_W = 17,
	parameter [CNT_W-1:0] HOLD = 17'd100000
) (
	input wire i_core_clk,
	input wire i_reset,
	input wire i_ce,
	input wire i_pin,
	output reg o_level,
	output reg o_rise,
	output reg o_fall
);
	reg sync1_r;
	reg sync2_r;
	reg [CNT_W-1:0] cnt_r;
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			cnt_r <= {CNT_W{1'b0}};
			o_level <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else if (i_ce) begin
			sync1_r <= i_pin;
			sync2_r <= sync1_r;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
			// a change must stand for the hold time before it is taken
			if (sync2_r == o_level) begin
				cnt_r <= {CNT_W{1'b0}};
			end else if (cnt_r == HOLD - 1'b1) begin
				cnt_r <= {CNT_W{1'b0}};
				o_level <= sync2_r;
				o_rise <= sync2_r;
				o_fall <= ~sync2_r;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule // ditd_debounce

// ===== testbench/ditd_props.sv
// assertions on the terminal decoder, seen only at the top module's ports
// assumes clock enable held high and configuration written over the port
module ditd_props (
	input wire i_core_clk,
	input wire i_reset,
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	input wire o_run,
	input wire o_jog,
	input wire o_coast_stop,
	input wire [1:0] o_ramp_sel,
	input wire o_overheat,
	input wire o_ext_fault,
	input wire o_yarn_stop,
	input wire o_fault_reset,
	input wire o_pid_enable,
	input wire [15:0] o_freq_offset
);
	reg [7:0] cfg_r;
	wire flt;
	assign flt = o_overheat | o_ext_fault | o_yarn_stop;
	// shadow of the configuration register
	always @(posedge i_core_clk) begin
		if (i_reset)
			cfg_r <= 8'h00;
		else if (i_wr && i_addr == 4'h6)
			cfg_r <= i_wdata[7:0];
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not idle");
	property p_frst_pulse;
		o_fault_reset |=> !o_fault_reset;
	endproperty
	a_frst_pulse: assert property (p_frst_pulse)
		else $error("fault reset longer than one cycle");
	property p_coast;
		$fell(o_jog) |-> ##[0:1] o_coast_stop;
	endproperty
	a_coast: assert property (p_coast)
		else $error("jog release without immediate stop");
	property p_jog_ramp;
		o_jog && $past(o_jog) |-> o_ramp_sel == 2'h3;
	endproperty
	a_jog_ramp: assert property (p_jog_ramp)
		else $error("jog not on ramp set four");
	property p_run_src;
		$rose(o_run) |-> cfg_r[0];
	endproperty
	a_run_src: assert property (p_run_src)
		else $error("run started without terminal source");
	property p_fault_off;
		flt && $past(flt) |-> !o_run;
	endproperty
	a_fault_off: assert property (p_fault_off)
		else $error("running during a fault");
	property p_jog_stopped;
		$rose(o_jog) |-> !$past(o_run);
	endproperty
	a_jog_stopped: assert property (p_jog_stopped)
		else $error("jog accepted while running");
	property p_offset_hold;
		!o_run && !$past(o_run) |-> $stable(o_freq_offset);
	endproperty
	a_offset_hold: assert property (p_offset_hold)
		else $error("offset changed in standby");
	property p_seg_ramp;
		$past(cfg_r[2:1], 2) == 2'h1 && cfg_r[2:1] == 2'h1 && !o_jog
			&& !$past(o_jog) |-> o_ramp_sel == 2'h0;
	endproperty
	a_seg_ramp: assert property (p_seg_ramp)
		else $error("ramp select honoured in segment mode one");
	property p_pid_run;
		o_pid_enable |-> o_run || $past(o_run);
	endproperty
	a_pid_run: assert property (p_pid_run)
		else $error("regulator enabled while stopped");
	c_coast: cover property (o_coast_stop);
	c_run: cover property ($rose(o_run) && cfg_r[0]);
	c_jog: cover property (o_jog ##1 !o_jog);
endmodule // ditd_props

bind ditd_top ditd_props u_props (
	.i_core_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.o_run, .o_jog, .o_coast_stop, .o_ramp_sel, .o_overheat, .o_ext_fault,
	.o_yarn_stop, .o_fault_reset, .o_pid_enable, .o_freq_offset
);

// ===== testbench/ditd_contacts.sv
// contact bank on the six terminals: every change bounces, then settles
// assumes the bench sets the wanted contact state right after an edge
module ditd_contacts (
	input wire i_core_clk,
	input wire [5:0] i_close,
	output reg [5:0] o_terminal = 6'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [5:0] last_r = 6'h00;
	integer bnc [0:5] = '{default: 0};
	integer i;
	// three extra toggles after each change, shorter than the debounce
	always @(posedge i_core_clk) begin
		for (i = 0; i < 6; i = i + 1) begin
			if (i_close[i] != last_r[i]) begin
				last_r[i] <= i_close[i];
				bnc[i] <= 3;
				o_terminal[i] <= ~o_terminal[i];
			end else if (bnc[i] != 0) begin
				bnc[i] <= bnc[i] - 1;
				o_terminal[i] <= ~o_terminal[i];
			end else begin
				o_terminal[i] <= last_r[i];
			end
		end
	end
endmodule // ditd_contacts

// ===== testbench/drive_input_terminal_decoder_test.sv
// self-checking bench for the terminal decoder with a bouncing contact bank
// assumes short debounce and repeat counts set through the parameters
module drive_input_terminal_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [47:0] RST_FN = 48'h1817160e0302;
	localparam [47:0] FLG_FN = 48'h211d0d0c0f0b;
	reg i_core_clk = 1'b0;
	reg i_reset = 1'b1;
	reg i_panel_key = 1'b0;
	reg [3:0] i_addr = 4'h0;
	reg [31:0] i_wdata = 32'h0;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg [5:0] close_r = 6'h00;
	reg [15:0] seed = 16'h629a;
	wire [5:0] i_terminal;
	wire [31:0] o_rdata;
	wire [1:0] o_ramp_sel, o_hml_sel;
	wire [3:0] o_seg_speed;
	wire [15:0] o_freq_offset;
	wire o_run, o_reverse, o_jog, o_coast_stop, o_force_main_freq;
	wire o_force_second_analog, o_force_keyboard, o_overheat, o_ext_fault;
	wire o_fault_reset, o_pid_enable, o_draft_enable, o_yarn_stop;
	wire o_timer1_done, o_timer2_done, o_zero_count_display;
	wire [5:0] flags;
	integer n_errors = 0, samples_checked = 0, n_frst = 0, cyc = 0, k;
	assign flags = {o_force_main_freq, o_force_second_analog, o_overheat,
		o_ext_fault, o_draft_enable, o_yarn_stop};
	ditd_top #(.DEB_CYC(32'h4), .RPT_FAST_CYC(32'h40),
		.RPT_SLOW_CYC(32'h80)) uut (
		.i_core_clk, .i_reset, .i_ce(1'b1), .i_terminal, .i_panel_key,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_run, .o_reverse,
		.o_jog, .o_coast_stop, .o_ramp_sel, .o_seg_speed, .o_hml_sel,
		.o_force_main_freq, .o_force_second_analog, .o_force_keyboard,
		.o_overheat, .o_ext_fault, .o_fault_reset, .o_pid_enable,
		.o_draft_enable, .o_yarn_stop, .o_timer1_done, .o_timer2_done,
		.o_zero_count_display, .o_freq_offset);
	ditd_contacts u_contacts (.i_core_clk, .i_close(close_r),
		.o_terminal(i_terminal));
	initial begin
		forever #10 i_core_clk = ~i_core_clk;
	end
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task print_verdict;
		begin
			$display("checks %0d errors %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (o_fault_reset === 1'b1)
			n_frst <= n_frst + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			print_verdict;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge i_core_clk);
			i_wr <= 1'b1;
			i_addr <= a;
			i_wdata <= d;
			@(posedge i_core_clk);
			i_wr <= 1'b0;
		end
	endtask
	task rd_chk(input [3:0] a, input [31:0] exp);
		begin
			@(posedge i_core_clk);
			i_rd <= 1'b1;
			i_addr <= a;
			@(posedge i_core_clk);
			i_rd <= 1'b0;
			#1;
			chk(o_rdata, exp);
		end
	endtask
	task fns(input [47:0] f);
		integer i;
		for (i = 0; i < 6; i = i + 1)
			wr(i[3:0], {24'h0, f[8*i+:8]});
	endtask
	// contacts take the new state, then bounce and debounce settle
	task set(input [5:0] c);
		begin
			@(posedge i_core_clk);
			close_r <= c;
			repeat (24) @(posedge i_core_clk);
			#1;
		end
	endtask
	task press_key;
		begin
			@(posedge i_core_clk);
			i_panel_key <= 1'b1;
			repeat (24) @(posedge i_core_clk);
			i_panel_key <= 1'b0;
			repeat (24) @(posedge i_core_clk);
			#1;
		end
	endtask
	task done(input string s);
		$display("test %0s done", s);
	endtask
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_reset <= 1'b0;
		for (k = 0; k < 6; k = k + 1)
			rd_chk(k[3:0], {24'h0, RST_FN[8*k+:8]});
		rd_chk(4'h6, 32'h0);
		rd_chk(4'h7, 32'h32);
		rd_chk(4'h8, 32'h1f4);
		rd_chk(4'ha, 32'h02faf080);
		rd_chk(4'hc, 32'h1);
		wr(4'hf, 32'h5a);
		rd_chk(4'hf, 32'h0);
		wr(4'h7, 32'h2710);
		rd_chk(4'h7, 32'h2710);
		wr(4'h7, 32'h2711);
		rd_chk(4'h7, 32'h2710);
		done("registers");
		for (k = 0; k < 6; k = k + 1) begin
			wr(4'h3, {24'h0, FLG_FN[8*k+:8]});
			set(6'h08);
			chk(flags, 32'h20 >> k);
			set(6'h00);
		end
		wr(4'h0, 32'h21);
		set(6'h01);
		chk(flags, 32'h0);
		wr(4'h0, 32'h0);
		chk({o_run, o_jog, flags}, 32'h0);
		set(6'h04);
		set(6'h00);
		chk(n_frst, 32'h1);
		done("flags");
		fns(48'h121100000000);
		for (k = 0; k < 4; k = k + 1) begin
			set({k[1:0], 4'h0});
			chk(o_ramp_sel, k);
		end
		wr(4'h6, 32'h2);
		set(6'h30);
		chk(o_ramp_sel, 32'h0);
		wr(4'h6, 32'h4);
		fns(48'h181716000000);
		for (k = 0; k < 8; k = k + 1) begin
			set({k[2:0], 3'h0});
			chk(o_hml_sel, k[0] ? 3 : k[1] ? 2 : k[2] ? 1 : 0);
		end
		fns(48'h00001a151413);
		for (k = 0; k < 4; k = k + 1) begin
			seed = lfsr(seed);
			set({2'h0, seed[3:0]});
			chk(o_seg_speed, seed[3:0]);
		end
		done("selects");
		set(6'h00);
		wr(4'h6, 32'h10);
		fns(48'h201f);
		repeat (3) begin
			set(6'h01);
			set(6'h00);
		end
		rd_chk(4'hd, 32'h3);
		chk(o_zero_count_display, 32'h0);
		set(6'h02);
		set(6'h00);
		rd_chk(4'hd, 32'h0);
		chk(o_zero_count_display, 32'h1);
		set(6'h01);
		set(6'h00);
		press_key;
		rd_chk(4'hd, 32'h0);
		wr(4'h6, 32'h08);
		press_key;
		chk(o_force_keyboard, 32'h1);
		press_key;
		chk(o_force_keyboard, 32'h0);
		fns(48'h0a09);
		wr(4'ha, 32'h10);
		wr(4'hb, 32'h10);
		set(6'h03);
		chk({o_timer2_done, o_timer1_done}, 32'h0);
		repeat (16) @(posedge i_core_clk);
		#1;
		chk({o_timer2_done, o_timer1_done}, 32'h3);
		set(6'h00);
		done("counter");
		wr(4'h6, 32'h0);
		fns(48'h191c1b0501);
		set(6'h01);
		chk(o_run, 32'h0);
		set(6'h00);
		wr(4'h6, 32'h1);
		set(6'h01);
		chk({o_run, o_reverse}, 32'h2);
		set(6'h03);
		chk({o_run, o_reverse}, 32'h3);
		set(6'h13);
		chk(o_pid_enable, 32'h1);
		set(6'h01);
		set(6'h05);
		set(6'h01);
		set(6'h05);
		set(6'h01);
		set(6'h09);
		set(6'h01);
		chk(o_freq_offset, 32'h1);
		set(6'h0d);
		chk(o_freq_offset, 32'h1);
		set(6'h12);
		chk({o_run, o_reverse, o_pid_enable}, 32'h2);
		set(6'h06);
		set(6'h00);
		chk(o_freq_offset, 32'h1);
		done("two wire");
		fns(48'h07040302);
		set(6'h04);
		set(6'h05);
		set(6'h04);
		chk({o_run, o_reverse}, 32'h2);
		set(6'h06);
		set(6'h04);
		chk({o_run, o_reverse}, 32'h3);
		set(6'h00);
		chk(o_run, 32'h0);
		set(6'h04);
		set(6'h0c);
		chk({o_jog, o_reverse, o_ramp_sel}, 32'hb);
		set(6'h0d);
		set(6'h0c);
		set(6'h04);
		chk({o_jog, o_run}, 32'h0);
		set(6'h05);
		set(6'h04);
		set(6'h0c);
		chk({o_jog, o_run, o_ramp_sel}, 32'h4);
		set(6'h00);
		done("three wire");
		print_verdict;
	end
endmodule // drive_input_terminal_decoder_test
